/* ssw_defs.vh */
// Constants for the supply supervisor reset and watchdog block
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH

`define SSW_CLK_HZ          10000000
`define SSW_CYC_PER_MS      (`SSW_CLK_HZ / 1000)
`define SSW_CYC_PER_US      (`SSW_CLK_HZ / 1000000)

`define SSW_RT_PF_PER_MS    83
`define SSW_WT_PF_PER_MS    10
`define SSW_RST_MIN_US      250
`define SSW_RST_MIN_CYC     (`SSW_RST_MIN_US * `SSW_CYC_PER_US)
`define SSW_RST_FIXED_MS    200
`define SSW_WDU_MIN_MS      2
// 1.6 s expressed in ms
`define SSW_WDU_FIXED_MS    1600
`define SSW_INIT_OPEN_SHIFT 3
`define SSW_INIT_VCC_SHIFT  6

`define SSW_PIN_CAP         2'h0
`define SSW_PIN_OPEN        2'h1
`define SSW_PIN_VCC         2'h2
`define SSW_SEL_GND         2'h0
`define SSW_SEL_OPEN        2'h1
`define SSW_SEL_VCC         2'h2

`define SSW_OFS_CTRL        8'h00
`define SSW_OFS_RST_CAP     8'h04
`define SSW_OFS_WD_CAP      8'h08
`define SSW_OFS_STATUS      8'h0C

`define SSW_CTRL_RT_LSB     0
`define SSW_CTRL_WT_LSB     2
`define SSW_CTRL_SEL_LSB    4
`define SSW_CTRL_RST        6'h15
`define SSW_CAP_RST         16'h0000

`define SSW_ST_SYSRST_BIT   0
`define SSW_ST_WDO_BIT      1
`define SSW_ST_INIT_BIT     2
`define SSW_ST_CH_LSB       3

`endif

/* ssw_glitch_filter.v */
// Per-channel integrating filter on comparator results
`timescale 1ns/1ns
`include "ssw_defs.vh"
module ssw_glitch_filter #(
  parameter       N_CH     = 4,
  parameter [7:0] FILT_LEN = 8'h08
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire [N_CH-1:0] raw_ok,
  output wire [N_CH-1:0] filt_ok
);
  genvar i;
  generate
    for (i = 0; i < N_CH; i = i + 1) begin : g_ch
      reg [7:0] cnt_r;
      reg       ok_r;
      // Integrate up and down; output flips only at the rails
      always @(posedge ref_clk) begin
        if (rst) begin
          cnt_r <= 8'h00;
          ok_r  <= 1'b0;
        end else begin
          if (raw_ok[i] && (cnt_r != FILT_LEN)) begin
            cnt_r <= cnt_r + 8'h01;
          end else if (!raw_ok[i] && (cnt_r != 8'h00)) begin
            cnt_r <= cnt_r - 8'h01;
          end
          if (cnt_r == FILT_LEN) begin
            ok_r <= 1'b1;
          end else if (cnt_r == 8'h00) begin
            ok_r <= 1'b0;
          end
        end
      end
      assign filt_ok[i] = ok_r;
    end
  endgenerate
endmodule

/* ssw_timeout_timer.v */
// Fractional-step timeout counter
`timescale 1ns/1ns
`include "ssw_defs.vh"
module ssw_timeout_timer #(
  parameter ACC_W = 40
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             clear,
  input  wire             run,
  input  wire [7:0]       step,
  input  wire [ACC_W-1:0] target,
  output wire             done
);
  reg [ACC_W-1:0] acc_r;

  // Step per clock against a target scaled by the same factor avoids a divider
  assign done = run && (acc_r >= target);

  always @(posedge ref_clk) begin
    if (rst || clear) begin
      acc_r <= {ACC_W{1'b0}};
    end else if (run && (acc_r < target)) begin
      acc_r <= acc_r + {{(ACC_W-8){1'b0}}, step};
    end
  end
endmodule

/* ssw_supervisor.v */
// Supply supervisor: reset timing, watchdog and APB configuration
`timescale 1ns/1ns
`include "ssw_defs.vh"
// Behaviour
// - Any low supply drives reset low
// - Recovery starts reset timer unless disabled
// - Supply loss during timeout restarts timer
// - Reset timeout scales 83 pF per ms
// - Open timing pin gives 250 us
// - Timing pin at supply gives 200 ms
// - Integrate comparators, ignore brief glitches
// - Expiry latches fault low, forces reset
// - Kick ignored while reset low
// - Expiry holds reset full reset timeout
// - Reset release restarts watchdog, initial interval
// - First kick after release clears fault
// - Missing kick after release expires again
// - Manual reset acts like supply event
// - Watchdog timeout scales 10 pF per ms
// - Watchdog open 2 ms, supply 1.6 s
// - Select gives 1x, 8x, 64x first timeout
// - After first kick use upper timeout
module ssw_supervisor #(
  parameter             N_CH          = 4,
  parameter [7:0]       FILT_LEN      = 8'h08,
  parameter             ACC_W         = 40,
  parameter [ACC_W-1:0] RST_FIXED_CYC = `SSW_RST_FIXED_MS * `SSW_CYC_PER_MS,
  parameter [ACC_W-1:0] WDU_MIN_CYC   = `SSW_WDU_MIN_MS * `SSW_CYC_PER_MS,
  parameter [ACC_W-1:0] WDU_FIXED_CYC = `SSW_WDU_FIXED_MS * `SSW_CYC_PER_MS
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire [N_CH-1:0] supply_ok_in,
  input  wire            manual_reset_in,
  input  wire            reset_timer_disable,
  input  wire            watchdog_kick_in,
  output wire            sys_reset_out_n,
  output wire            watchdog_fault_out_n,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output wire [31:0]     prdata,
  output wire            pready,
  output wire            pslverr
);
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_TIME = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  localparam [ACC_W-1:0] CYC_MS      = `SSW_CYC_PER_MS;
  localparam [ACC_W-1:0] RST_MIN_CYC = `SSW_RST_MIN_CYC;
  localparam [7:0]       RT_STEP     = `SSW_RT_PF_PER_MS;
  localparam [7:0]       WT_STEP     = `SSW_WT_PF_PER_MS;
  localparam [7:0]       UNIT_STEP   = 8'h01;

  // Register file
  reg  [1:0]       rt_mode_r;
  reg  [1:0]       wt_mode_r;
  reg  [1:0]       init_sel_r;
  reg  [15:0]      rst_cap_r;
  reg  [15:0]      wd_cap_r;
  reg  [31:0]      prdata_r;
  reg              pslverr_r;

  // Core state
  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg              sys_rst_n_r;
  reg              wdo_n_r;
  reg              init_phase_r;
  reg              kick_s1_r;
  reg              kick_s2_r;
  reg              kick_s3_r;

  wire [N_CH-1:0]  filt_ok;
  wire             all_ok;
  wire             kick_edge;
  wire             kick_valid;
  wire             rst_done;
  wire             wd_done;
  wire             wd_expire;
  wire             rst_clear;
  wire             rst_run;
  wire             wd_clear;
  wire             wd_run;
  wire             apb_wr;
  wire             apb_setup;

  reg  [7:0]       rst_step;
  reg  [ACC_W-1:0] rst_target;
  reg  [7:0]       wd_step;
  reg  [ACC_W-1:0] wd_upper;
  reg  [ACC_W-1:0] wd_target;
  reg              addr_ok;
  reg  [31:0]      rd_mux;

  ssw_glitch_filter #(
    .N_CH     (N_CH),
    .FILT_LEN (FILT_LEN)
  ) u_filter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw_ok  (supply_ok_in),
    .filt_ok (filt_ok)
  );

  // Manual reset is folded into the supply condition
  assign all_ok = (&filt_ok) && !manual_reset_in;

  // Kick synchroniser; first stage feeds only the second
  always @(posedge ref_clk) begin
    if (rst) begin
      kick_s1_r <= 1'b0;
      kick_s2_r <= 1'b0;
      kick_s3_r <= 1'b0;
    end else begin
      kick_s1_r <= watchdog_kick_in;
      kick_s2_r <= kick_s1_r;
      kick_s3_r <= kick_s2_r;
    end
  end

  assign kick_edge  = kick_s2_r ^ kick_s3_r;
  // Only counted while reset is released
  assign kick_valid = kick_edge && (state_r == ST_RUN);

  // Reset timeout selection
  always @* begin
    rst_step   = UNIT_STEP;
    rst_target = RST_MIN_CYC;
    case (rt_mode_r)
      `SSW_PIN_CAP: begin
        rst_step   = RT_STEP;
        rst_target = {{(ACC_W-16){1'b0}}, rst_cap_r} * CYC_MS;
      end
      `SSW_PIN_VCC: begin
        rst_target = RST_FIXED_CYC;
      end
      default: begin
        rst_target = RST_MIN_CYC;
      end
    endcase
  end

  // Watchdog timeout selection
  always @* begin
    wd_step  = UNIT_STEP;
    wd_upper = WDU_MIN_CYC;
    case (wt_mode_r)
      `SSW_PIN_CAP: begin
        wd_step  = WT_STEP;
        wd_upper = {{(ACC_W-16){1'b0}}, wd_cap_r} * CYC_MS;
      end
      `SSW_PIN_VCC: begin
        wd_upper = WDU_FIXED_CYC;
      end
      default: begin
        wd_upper = WDU_MIN_CYC;
      end
    endcase
    wd_target = wd_upper;
    if (init_phase_r) begin
      case (init_sel_r)
        `SSW_SEL_GND: wd_target = wd_upper;
        `SSW_SEL_VCC: wd_target = wd_upper << `SSW_INIT_VCC_SHIFT;
        default:      wd_target = wd_upper << `SSW_INIT_OPEN_SHIFT;
      endcase
    end
  end

  // Timer clears whenever the reset sequence is not counting
  assign rst_run   = (state_r == ST_TIME);
  assign rst_clear = (state_r != ST_TIME) || !all_ok;

  ssw_timeout_timer #(
    .ACC_W (ACC_W)
  ) u_rst_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (rst_clear),
    .run     (rst_run),
    .step    (rst_step),
    .target  (rst_target),
    .done    (rst_done)
  );

  // Held clear through reset, so release starts it from zero
  assign wd_run    = (state_r == ST_RUN);
  assign wd_clear  = !wd_run || kick_valid;
  assign wd_expire = wd_done && !kick_valid;

  ssw_timeout_timer #(
    .ACC_W (ACC_W)
  ) u_wd_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (wd_clear),
    .run     (wd_run),
    .step    (wd_step),
    .target  (wd_target),
    .done    (wd_done)
  );

  // Reset sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (all_ok && !reset_timer_disable) begin
          state_nxt = ST_TIME;
        end
      end
      ST_TIME: begin
        // Disable also stops a timeout already running, so reset stays low
        if (!all_ok || reset_timer_disable) begin
          state_nxt = ST_HOLD;
        end else if (rst_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!all_ok) begin
          state_nxt = ST_HOLD;
        end else if (wd_expire) begin
          // Straight into timing so reset stays low a full timeout
          state_nxt = ST_TIME;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_r      <= ST_HOLD;
      sys_rst_n_r  <= 1'b0;
      wdo_n_r      <= 1'b1;
      init_phase_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      sys_rst_n_r <= (state_nxt == ST_RUN);
      // A kick landing in the same cycle as expiry wins and blocks it
      if (wd_expire && (state_r == ST_RUN)) begin
        wdo_n_r <= 1'b0;
      end else if (kick_valid) begin
        wdo_n_r <= 1'b1;
      end
      if (state_r != ST_RUN) begin
        init_phase_r <= 1'b1;
      end else if (kick_valid) begin
        init_phase_r <= 1'b0;
      end
    end
  end

  assign sys_reset_out_n      = sys_rst_n_r;
  assign watchdog_fault_out_n = wdo_n_r;

  // APB slave, zero wait states
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && addr_ok;

  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `SSW_OFS_CTRL: begin
        rd_mux[`SSW_CTRL_RT_LSB+1:`SSW_CTRL_RT_LSB]   = rt_mode_r;
        rd_mux[`SSW_CTRL_WT_LSB+1:`SSW_CTRL_WT_LSB]   = wt_mode_r;
        rd_mux[`SSW_CTRL_SEL_LSB+1:`SSW_CTRL_SEL_LSB] = init_sel_r;
      end
      `SSW_OFS_RST_CAP: rd_mux[15:0] = rst_cap_r;
      `SSW_OFS_WD_CAP:  rd_mux[15:0] = wd_cap_r;
      `SSW_OFS_STATUS: begin
        rd_mux[`SSW_ST_SYSRST_BIT]                = sys_rst_n_r;
        rd_mux[`SSW_ST_WDO_BIT]                   = wdo_n_r;
        rd_mux[`SSW_ST_INIT_BIT]                  = init_phase_r;
        rd_mux[`SSW_ST_CH_LSB+N_CH-1:`SSW_ST_CH_LSB] = filt_ok;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rt_mode_r  <= 2'h1;
      wt_mode_r  <= 2'h1;
      init_sel_r <= 2'h1;
      rst_cap_r  <= `SSW_CAP_RST;
      wd_cap_r   <= `SSW_CAP_RST;
      prdata_r   <= 32'h0000_0000;
      pslverr_r  <= 1'b0;
    end else begin
      // Sample read data and error in setup so they stand in access
      if (apb_setup) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !addr_ok || (pwrite && (paddr == `SSW_OFS_STATUS));
      end
      if (apb_wr) begin
        case (paddr)
          `SSW_OFS_CTRL: begin
            rt_mode_r  <= pwdata[`SSW_CTRL_RT_LSB+1:`SSW_CTRL_RT_LSB];
            wt_mode_r  <= pwdata[`SSW_CTRL_WT_LSB+1:`SSW_CTRL_WT_LSB];
            init_sel_r <= pwdata[`SSW_CTRL_SEL_LSB+1:`SSW_CTRL_SEL_LSB];
          end
          `SSW_OFS_RST_CAP: rst_cap_r <= pwdata[15:0];
          `SSW_OFS_WD_CAP:  wd_cap_r  <= pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r;
endmodule

/* ssw_sup_asserts.sv */
// Checker for reset sequencing, watchdog fault and APB answers
`timescale 1ns/1ns
module ssw_sup_asserts #(
  parameter N_CH = 4
) (
  input wire            ref_clk,
  input wire            rst,
  input wire [N_CH-1:0] supply_ok_in,
  input wire            manual_reset_in,
  input wire            reset_timer_disable,
  input wire            watchdog_kick_in,
  input wire            sys_reset_out_n,
  input wire            watchdog_fault_out_n,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [7:0]      paddr,
  input wire            pready,
  input wire            pslverr
);
  reg  [4:0] ok_cnt_r;
  reg  [4:0] bad_cnt_r;
  reg  [3:0] kick_age_r;
  reg        kick_q_r;
  wire       all_ok   = &supply_ok_in && !manual_reset_in && !reset_timer_disable;
  wire       kick_chg = kick_q_r != watchdog_kick_in;
  // Saturating run lengths, so long waits never wrap
  always @(posedge ref_clk) begin
    kick_q_r <= watchdog_kick_in;
    if (rst) begin
      ok_cnt_r   <= 5'h00;
      bad_cnt_r  <= 5'h00;
      kick_age_r <= 4'hF;
    end else begin
      ok_cnt_r   <= !all_ok ? 5'h00 : ok_cnt_r + {4'h0, ok_cnt_r != 5'h1F};
      bad_cnt_r  <= &supply_ok_in ? 5'h00 : bad_cnt_r + {4'h0, bad_cnt_r != 5'h1F};
      kick_age_r <= kick_chg ? 4'h0 : kick_age_r + {3'h0, kick_age_r != 4'hF};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RISE_NEEDS_OK: assert property ($rose(sys_reset_out_n) |-> ok_cnt_r >= 5'h02)
    else $error("reset released without valid inputs");
  AST_MANUAL_LOW: assert property (manual_reset_in |=> !sys_reset_out_n)
    else $error("manual request did not assert reset");
  AST_DISABLE_HOLD: assert property (reset_timer_disable && !sys_reset_out_n |=> !sys_reset_out_n)
    else $error("reset released while timer disabled");
  AST_FAULT_WITH_RST: assert property ($fell(watchdog_fault_out_n) |-> $fell(sys_reset_out_n))
    else $error("fault fell without reset");
  AST_KICK_IGNORED: assert property (!sys_reset_out_n && !watchdog_fault_out_n |=> !watchdog_fault_out_n)
    else $error("fault cleared during reset");
  AST_FAULT_CLEAR: assert property ($rose(watchdog_fault_out_n) |-> kick_age_r <= 4'h6 && sys_reset_out_n)
    else $error("fault cleared without kick");
  AST_GLITCH_REJECT: assert property ($fell(sys_reset_out_n) |->
    !watchdog_fault_out_n || $past(manual_reset_in) || bad_cnt_r >= 5'h07)
    else $error("reset on short glitch");
  AST_PREADY: assert property (psel |-> pready)
    else $error("pready low");
  AST_BAD_ADDR: assert property (psel && penable && (paddr > 8'h0C || (pwrite && paddr == 8'h0C))
    |-> pslverr)
    else $error("refused access without pslverr");
  CV_EXPIRY: cover property ($fell(watchdog_fault_out_n));
  CV_MANUAL: cover property (manual_reset_in ##1 !sys_reset_out_n);
  CV_ERR: cover property (psel && penable && pslverr);
endmodule
bind ssw_supervisor ssw_sup_asserts #(.N_CH(N_CH)) u_chk (
  .ref_clk              (ref_clk),
  .rst                  (rst),
  .supply_ok_in         (supply_ok_in),
  .manual_reset_in      (manual_reset_in),
  .reset_timer_disable  (reset_timer_disable),
  .watchdog_kick_in     (watchdog_kick_in),
  .sys_reset_out_n      (sys_reset_out_n),
  .watchdog_fault_out_n (watchdog_fault_out_n),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pready               (pready),
  .pslverr              (pslverr)
);

/* ssw_cpu_model.sv */
// Processor model: periodic watchdog kicks and reset cause capture
`timescale 1ns/1ns
module ssw_cpu_model #(
  parameter PERIOD = 100
) (
  input  wire ref_clk,
  input  wire kick_en,
  input  wire sys_reset_out_n,
  input  wire watchdog_fault_out_n,
  output reg  watchdog_kick_in,
  output reg  wd_cause
);
  int cnt_r   = 0;
  reg rst_q_r = 1'b0;
  initial watchdog_kick_in = 1'b0;
  initial wd_cause = 1'b0;
  always @(posedge ref_clk) begin
    cnt_r   <= (kick_en && cnt_r < PERIOD - 1) ? cnt_r + 1 : 0;
    rst_q_r <= sys_reset_out_n;
    // Period kept well inside the upper timeout
    if (kick_en && cnt_r == PERIOD - 1)
      watchdog_kick_in <= ~watchdog_kick_in;
    if (sys_reset_out_n && !rst_q_r)
      wd_cause <= !watchdog_fault_out_n;
  end
endmodule

/* tb.sv */
// Testbench for supervisor reset timing, watchdog and registers
`timescale 1ns/1ns
module tb;
  logic        ref_clk             = 1'b0;
  logic        rst                 = 1'b1;
  logic [3:0]  supply_ok_in        = 4'hF;
  logic        manual_reset_in     = 1'b0;
  logic        reset_timer_disable = 1'b0;
  logic        kick_en             = 1'b0;
  logic        psel                = 1'b0;
  logic        penable             = 1'b0;
  logic        pwrite              = 1'b0;
  logic [7:0]  paddr               = 8'h00;
  logic [31:0] pwdata              = 32'h0000_0000;
  wire         watchdog_kick_in, sys_reset_out_n, watchdog_fault_out_n;
  wire         pready, pslverr, wd_cause;
  wire  [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  ctl [5]  = '{8'h04, 8'h14, 8'h24, 8'h08, 8'h00};
  int          wdt [5]  = '{200, 1600, 12800, 400, 1000};
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          n;
  int          i;
  ssw_supervisor #(.RST_FIXED_CYC(40'h012C), .WDU_MIN_CYC(40'h00C8),
    .WDU_FIXED_CYC(40'h0190)) i_dut (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .supply_ok_in         (supply_ok_in),
    .manual_reset_in      (manual_reset_in),
    .reset_timer_disable  (reset_timer_disable),
    .watchdog_kick_in     (watchdog_kick_in),
    .sys_reset_out_n      (sys_reset_out_n),
    .watchdog_fault_out_n (watchdog_fault_out_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr)
  );
  ssw_cpu_model i_cpu (
    .ref_clk              (ref_clk),
    .kick_en              (kick_en),
    .sys_reset_out_n      (sys_reset_out_n),
    .watchdog_fault_out_n (watchdog_fault_out_n),
    .watchdog_kick_in     (watchdog_kick_in),
    .wd_cause             (wd_cause)
  );
  initial forever #50 ref_clk = ~ref_clk;
  task automatic print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      print_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
    check(err, ee);
  endtask
  task automatic wait_lvl(input logic lvl);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sys_reset_out_n !== lvl);
  endtask
  task automatic pulse;
    @(posedge ref_clk);
    manual_reset_in <= 1'b1;
    @(posedge ref_clk);
    manual_reset_in <= 1'b0;
  endtask
  task automatic drop;
    @(posedge ref_clk);
    supply_ok_in <= 4'h7;
    repeat (20) @(posedge ref_clk);
    supply_ok_in <= 4'hF;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wait_lvl(1'b1);
    rng(n, 2500, 2530);
    check(watchdog_fault_out_n, 1'b1);
    rdc(8'h00, 32'h0000_0015, 1'b0);
    rdc(8'h04, 32'h0000_0000, 1'b0);
    rdc(8'h08, 32'h0000_0000, 1'b0);
    rdc(8'h10, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    check(err, 1'b1);
    rdc(8'h0C, 32'h0000_007F, 1'b0);
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0004);
    kick_en <= 1'b1;
    repeat (150) @(posedge ref_clk);
    supply_ok_in <= 4'hD;
    repeat (3) @(posedge ref_clk);
    supply_ok_in <= 4'hF;
    repeat (40) @(posedge ref_clk);
    check(sys_reset_out_n, 1'b1);
    pulse;
    wait_lvl(1'b1);
    rng(n, 121, 140);
    check(watchdog_fault_out_n, 1'b1);
    drop;
    repeat (60) @(posedge ref_clk);
    drop;
    wait_lvl(1'b1);
    rng(n, 121, 150);
    pulse;
    reset_timer_disable <= 1'b1;
    repeat (300) @(posedge ref_clk);
    check(sys_reset_out_n, 1'b0);
    reset_timer_disable <= 1'b0;
    wait_lvl(1'b1);
    rng(n, 121, 140);
    apb(1'b1, 8'h00, 32'h0000_0006);
    pulse;
    wait_lvl(1'b1);
    rng(n, 300, 320);
    kick_en <= 1'b0;
    // Each select and timing mode, run to expiry without kicks
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, {24'h00_0000, ctl[i]});
      pulse;
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      rng(n, wdt[i], wdt[i] + 10);
      check(watchdog_fault_out_n, 1'b0);
      wait_lvl(1'b1);
      rng(n, 121, 140);
      repeat (2) @(posedge ref_clk);
      check(wd_cause, 1'b1);
    end
    apb(1'b1, 8'h00, 32'h0000_0024);
    pulse;
    kick_en <= 1'b1;
    wait_lvl(1'b1);
    check(watchdog_fault_out_n, 1'b0);
    repeat (120) @(posedge ref_clk);
    kick_en <= 1'b0;
    check(watchdog_fault_out_n, 1'b1);
    wait_lvl(1'b0);
    rng(n, 100, 210);
    print_verdict;
  end
endmodule
